// [bench/bcc_core_props.sv]
// Port checker for bcc_core.
// Assumes one clock; bound into every bcc_core.
`timescale 1ns/1ps
module bcc_core_props #(
  parameter [15:0] EE_TOP_ADDR = 16'hFFFF
)(
  input wire        i_core_clk,
  input wire        i_nrst,
  input wire        i_cmd_valid,
  input wire [63:0] i_cmd_frame,
  input wire [7:0]  i_region_sel,
  input wire        i_connect_seen,
  input wire        o_reply_valid,
  input wire [63:0] o_reply_frame,
  input wire        o_busy,
  input wire        o_commit,
  input wire        o_ee_erase,
  input wire [31:0] o_sector_mask,
  input wire        o_sig_wr,
  input wire [15:0] o_sig_addr,
  input wire [2:0]  o_rate_idx,
  input wire        o_link_restart,
  input wire [15:0] o_record_crc,
  input wire [15:0] o_image_crc
);
  // ==========
  // Helpers: a command only counts when taken outside the relink window
  reg        in_wait_ff;
  wire [7:0] op   = i_cmd_frame[63:56];
  wire       take = i_cmd_valid && !o_busy && !in_wait_ff && !o_link_restart;
  wire       szr  = i_cmd_frame[47:16] == 32'h0000_0000;
  wire       hit  = take && op == 8'h0E;
  wire [7:0] rc   = o_reply_frame[55:48];

  // Window is left open on timeout, which only mutes checks
  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      in_wait_ff <= 1'b0;
    else if (o_link_restart)
      in_wait_ff <= 1'b1;
    else if (i_connect_seen)
      in_wait_ff <= 1'b0;
  end

  // ==========
  // Properties
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  chk_reply_id: assert property (o_reply_valid |-> o_reply_frame[63:56] == 8'hFF)
    else $error("reply id byte wrong");
  chk_unlock_reply: assert property (take && op == 8'h13 |=> o_reply_valid
    && o_reply_frame[47:40] == $past(i_cmd_frame[55:48]) && (rc != 8'h00
    || (o_reply_frame[39:32] == $past(i_region_sel) && o_reply_frame[7:0] == 8'h02)))
    else $error("unlock reply wrong");
  chk_rec_error: assert property (hit && !szr && i_cmd_frame[15:0] != o_record_crc
    |=> o_reply_valid && rc == 8'h01 && !o_commit) else $error("record mismatch not refused");
  chk_rec_commit: assert property (hit && !szr && i_cmd_frame[15:0] == o_record_crc
    |=> o_commit && !o_reply_valid) else $error("record match not committed");
  chk_img_error: assert property (hit && szr && i_cmd_frame[15:0] != o_image_crc
    |=> o_reply_valid && rc == 8'h01) else $error("image mismatch not refused");
  chk_crc_rearm: assert property (hit && !szr |=> o_record_crc == 16'hFFFF)
    else $error("record crc not restarted");
  chk_action_quiet: assert property (take && op == 8'h21 |=> (!o_reply_valid) [*4])
    else $error("reply after action");
  chk_sector_mask: assert property (take && op == 8'h10 && i_region_sel == 8'h00
    |=> o_sector_mask == $past(i_cmd_frame[47:16])) else $error("sector mask wrong");
  chk_ee_erase: assert property (take && op == 8'h10 && i_region_sel[7:1] == 7'h01
    |-> ##[1:2] o_ee_erase) else $error("eeprom erase missing");
  chk_sig_addr: assert property (o_sig_wr |-> o_sig_addr == EE_TOP_ADDR - 16'h0001)
    else $error("signature address wrong");
  chk_rate_hold: assert property (o_rate_idx != $past(o_rate_idx)
    |-> o_link_restart || $past(o_link_restart)) else $error("rate changed alone");
endmodule

bind bcc_core bcc_core_props #(.EE_TOP_ADDR(EE_TOP_ADDR)) u_props (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid),
  .i_cmd_frame(i_cmd_frame), .i_region_sel(i_region_sel), .i_connect_seen(i_connect_seen),
  .o_reply_valid(o_reply_valid), .o_reply_frame(o_reply_frame), .o_busy(o_busy),
  .o_commit(o_commit), .o_ee_erase(o_ee_erase), .o_sector_mask(o_sector_mask),
  .o_sig_wr(o_sig_wr), .o_sig_addr(o_sig_addr), .o_rate_idx(o_rate_idx),
  .o_link_restart(o_link_restart), .o_record_crc(o_record_crc), .o_image_crc(o_image_crc));

// [bench/bcc_core_tb.sv]
// Bench for bcc_core: records, image check, unlock, clear, rate change.
// Assumes bcc_mem_model on the memory side and the bound checker.
`timescale 1ns/1ps
`include "bcc_defs.vh"
module bcc_core_tb;
  localparam [15:0] KF = 16'h1234;
  localparam [15:0] KB = 16'hABCD;
  localparam [15:0] KD = 16'h5A5A;
  localparam [63:0] MH = {24'hFF_FFFF, 40'h00_0000_0000};
  localparam [63:0] ALL = ~64'h0000_0000_0000_0000;
  reg         clk = 1'b0, nrst = 1'b0, cmd_v = 1'b0, dl_v = 1'b0, conn = 1'b0, jreq = 1'b0;
  reg  [63:0] frame = 64'h0000_0000_0000_0000;
  reg  [7:0]  rsel = 8'h00, dlb = 8'h00, seq = 8'h00;
  reg  [15:0] sig_st = 16'h0000, rec, img, sig;
  reg         got;
  wire        reply_v, busy, commit, ee_er, frd, sig_wr, lrst, jump, done;
  wire [63:0] rframe;
  wire [31:0] smask;
  wire [23:0] faddr;
  wire [15:0] sig_addr, sig_data, rec_crc, img_crc;
  wire [7:0]  frdata;
  wire [3:0]  unl;
  wire [2:0]  rate;
  integer     error_cnt = 0, check_count = 0, cyc = 0, i, k;

  bcc_core #(.KEY_FLASH(KF), .KEY_BOOTEE(KB), .KEY_DATAEE(KD), .FLASH_LAST(24'h00_00FF),
    .CONN_TMO_CYC(36'h0_0000_0064)) u_bcc_core (.i_core_clk(clk), .i_nrst(nrst),
    .i_cmd_valid(cmd_v), .i_cmd_frame(frame), .i_region_sel(rsel), .i_dl_valid(dl_v),
    .i_dl_byte(dlb), .i_connect_seen(conn), .i_jump_req(jreq), .i_mem_done(done),
    .i_flash_rdata(frdata), .i_sig_stored(sig_st), .o_reply_valid(reply_v),
    .o_reply_frame(rframe), .o_busy(busy), .o_commit(commit), .o_ee_erase(ee_er),
    .o_sector_mask(smask), .o_flash_rd(frd), .o_flash_addr(faddr), .o_sig_wr(sig_wr),
    .o_sig_addr(sig_addr), .o_sig_data(sig_data), .o_unlocked(unl), .o_rate_idx(rate),
    .o_link_restart(lrst), .o_jump(jump), .o_record_crc(rec_crc), .o_image_crc(img_crc));
  bcc_mem_model u_bcc_mem_model (.i_core_clk(clk), .i_commit(commit), .i_ee_erase(ee_er),
    .i_sector_mask(smask), .i_flash_rd(frd), .i_flash_addr(faddr), .o_mem_done(done),
    .o_flash_rdata(frdata));

  // ==========
  // Clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end

  // ==========
  // Helpers
  function [15:0] crc8(input [15:0] c, input [7:0] b);
    integer j;
    begin
      crc8 = c ^ {8'h00, b};
      for (j = 0; j < 8; j = j + 1)
        crc8 = crc8[0] ? ((crc8 >> 1) ^ `BCC_CRC_POLY) : (crc8 >> 1);
    end
  endfunction
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      if (error_cnt == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Strobes are one cycle wide, launched and dropped on falling edges
  task cmd(input [7:0] op, input [47:0] body);
    begin
      seq = seq + 8'h01;
      @(negedge clk);
      frame = {op, seq, body};
      cmd_v = 1'b1;
      @(negedge clk);
      cmd_v = 1'b0;
    end
  endtask
  task strobe(input integer s);
    begin
      @(negedge clk);
      if (s) conn = 1'b1; else jreq = 1'b1;
      @(negedge clk);
      conn = 1'b0;
      jreq = 1'b0;
    end
  endtask
  task dl(input [7:0] b);
    begin
      @(negedge clk);
      dl_v = 1'b1;
      dlb = b;
      rec = crc8(rec, b);
      img = crc8(img, b);
      @(negedge clk);
      dl_v = 1'b0;
    end
  endtask
  task wait_for(input integer sel, input integer lim);
    begin
      // Pulses stand edge to edge; look now, then at each falling edge
      got = 1'b0;
      for (i = 0; i < lim && got !== 1'b1; i = i + 1)
      begin
        if (i > 0)
          @(negedge clk);
        got = (sel == 0) ? reply_v : (sel == 1) ? sig_wr : (sel == 2) ? jump : !busy;
      end
    end
  endtask
  task rep(input [63:0] exp, input [63:0] m);
    begin
      wait_for(0, 100);
      chk(got, 1'b1);
      chk(rframe & m, exp & m);
    end
  endtask

  // ==========
  // Main sequence
  initial
  begin
    k = $urandom(87);
    repeat (4) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    rec = `BCC_CRC_INIT;
    img = `BCC_CRC_INIT;
    chk({rate, rec_crc, img_crc}, {3'd2, rec, img});
    // Host points at the key register before unlocking
    rsel = 8'h01;
    cmd(`BCC_OP_UNLOCK, {8'h02, 16'h0F0F, 24'h00_0000});
    rep({16'hFF01, seq, 40'h00_0000_0000}, MH);
    chk(unl, 4'h0);
    for (k = 0; k < 3; k = k + 1)
    begin
      cmd(`BCC_OP_UNLOCK, {8'h02, (k == 0) ? KF : (k == 1) ? KB : KD, 24'h00_0000});
      rep({16'hFF00, seq, 8'h01, 24'h00_0000, 8'h02}, ALL);
    end
    chk(unl, 4'hD);
    // Records: the middle one carries a bad host value
    rsel = 8'h00;
    for (k = 0; k < 3; k = k + 1)
    begin
      repeat (1 + $urandom % 6) dl(8'($urandom));
      @(negedge clk);
      chk(rec_crc, rec);
      cmd(`BCC_OP_CHECKSUM, {$urandom | 32'h0000_0001, (k == 1) ? ~rec : rec});
      if (k == 1)
        rep({16'hFF01, seq, 40'h00_0000_0000}, MH);
      else
        rep({16'hFF00, seq, 8'h00, rec, 16'h0000}, ALL);
      rec = `BCC_CRC_INIT;
      chk(rec_crc, rec);
    end
    cmd(`BCC_OP_CHECKSUM, {32'h0000_0000, ~img});
    rep({16'hFF01, seq, 40'h00_0000_0000}, MH);
    cmd(`BCC_OP_CHECKSUM, {32'h0000_0000, img});
    rep({16'hFF00, seq, 8'h00, img, 16'h0000}, ALL);
    sig = crc8(crc8(`BCC_CRC_INIT, 8'hA5), 8'h25);
    wait_for(1, 2000);
    chk({got, sig_data}, {1'b1, sig});
    wait_for(3, 2000);
    sig_st = ~sig;
    strobe(0);
    wait_for(2, 600);
    chk(got, 1'b0);
    sig_st = sig;
    strobe(0);
    wait_for(2, 600);
    chk(got, 1'b1);
    // Clears on flash, boot and data EEPROM
    for (k = 0; k < 3; k = k + 1)
    begin
      rsel = (k == 0) ? 8'h00 : 8'h01 + k[7:0];
      cmd(`BCC_OP_CLEAR, {$urandom | 32'h0000_0001, 16'h0000});
      rep({16'hFF00, seq, 40'h00_0000_0000}, ALL);
    end
    // Rate changes: bad type and index first
    rsel = 8'h01;
    cmd(`BCC_OP_ACTION, {16'h0082, 16'h0001, 16'h0000});
    cmd(`BCC_OP_ACTION, {16'h0081, 16'h0007, 16'h0000});
    repeat (5) @(negedge clk);
    chk(rate, 3'd2);
    cmd(`BCC_OP_ACTION, {16'h0081, 16'h0004, 16'h0000});
    chk(lrst, 1'b1);
    wait_for(0, 20);
    chk(got, 1'b0);
    chk(rate, 3'd4);
    cmd(`BCC_OP_UNLOCK, {8'h02, KF, 24'h00_0000});
    wait_for(0, 20);
    chk(got, 1'b0);
    strobe(1);
    cmd(`BCC_OP_UNLOCK, {8'h02, KF, 24'h00_0000});
    rep({16'hFF00, seq, 8'h01, 24'h00_0000, 8'h02}, ALL);
    chk(rate, 3'd4);
    cmd(`BCC_OP_ACTION, {16'h0081, 16'h0000, 16'h0000});
    wait_for(2, 1000);
    chk({got, rate}, {1'b1, 3'd0});
    final_report;
  end
endmodule

// [bench/bcc_mem_model.sv]
// Memory side: flash reads and commit or erase completion.
// Assumes bcc_core strobes; answers after DLY cycles.
`timescale 1ns/1ps
module bcc_mem_model #(
  parameter DLY = 7
)(
  input  wire        i_core_clk,
  input  wire        i_commit,
  input  wire        i_ee_erase,
  input  wire [31:0] i_sector_mask,
  input  wire        i_flash_rd,
  input  wire [23:0] i_flash_addr,
  output reg         o_mem_done = 1'b0,
  output reg  [7:0]  o_flash_rdata = 8'h00
);
  integer cnt = 0;
  reg     mask_ff = 1'b0;

  // ==========
  // Slow answer keeps the core busy for several cycles
  always @(posedge i_core_clk)
  begin
    mask_ff <= |i_sector_mask;
    o_mem_done <= (cnt == 1);
    if (i_commit || i_ee_erase || (|i_sector_mask && !mask_ff))
      cnt <= DLY;
    else if (cnt > 0)
      cnt <= cnt - 1;
    // Idle data toggles so a stale byte never looks valid
    o_flash_rdata <= i_flash_rd ? (i_flash_addr[7:0] ^ 8'hA5) : ~o_flash_rdata;
  end
endmodule

// [verilog/bcc_core.v]
// Boot command interpreter: checksum verify, memory clear, unlock, rate change.
// Assumes frames arrive as one 64-bit strobe and memory ports answer with done.
//
// Behaviour
// - Opcode 0E is checksum verify; reply compares host CRC with own CRC
// - Bytes 2-5 size; zero means whole image, else last record
// - Host CRC in bytes 6,7 compared with accumulated download CRC
// - On match reply no-error, region in byte 3, local CRC bytes 4,5
// - CRC16 init FFFF, xor byte low, 8 shifts right, xor A001 on carry
// - Record match commits buffer; mismatch returns error, no programming
// - Zero size compares full-image CRC; mismatch returns error
// - After good flash image check, CRC every 128th flash location
// - Store signature CRC at boot EEPROM two highest bytes
// - Jump only if recomputed signature matches stored; else stay connected
// - Clear opcode 10; EEPROM selected erases whole EEPROM
// - Flash selected: size is sector mask, bit n erases sector n
// - Key matched to table enables region; reply region byte3, 02 byte7
// - Action 21 acts only for type 0081, others ignored
// - Bytes 4,5 give rate index 0 to 5
// - Power-up rate index is the 250k / 19200 default
// - Rate change sends no reply, relinks and restarts handling
// - After rate restart wait 30 s for connect, then try flash jump
// - Changed rate kept until next change or power cycle
// - Every reply byte0 FF and echoes command sequence count
// - Region codes 0 flash, 1 config, 2 boot EEPROM, 3 data EEPROM
// - Downloaded bytes stay in record buffer until record check commits
`timescale 1ns/1ps
`include "bcc_defs.vh"
module bcc_core #(
  parameter [15:0] KEY_FLASH  = 16'h0000,
  parameter [15:0] KEY_BOOTEE = 16'h0000,
  parameter [15:0] KEY_DATAEE = 16'h0000,
  parameter        SIG_ADDR_W = 24,
  parameter [SIG_ADDR_W-1:0] FLASH_BASE = 24'h00_0000,
  parameter [SIG_ADDR_W-1:0] FLASH_LAST = 24'h00_FFFF,
  parameter [15:0] EE_TOP_ADDR = 16'hFFFF,
  parameter [35:0] CONN_TMO_CYC = `BCC_CONN_TMO_S * `BCC_CLK_HZ
)(
  input  wire                  i_core_clk,
  input  wire                  i_nrst,
  input  wire                  i_cmd_valid,
  input  wire [63:0]           i_cmd_frame,
  input  wire [7:0]            i_region_sel,
  input  wire                  i_dl_valid,
  input  wire [7:0]            i_dl_byte,
  input  wire                  i_connect_seen,
  input  wire                  i_jump_req,
  input  wire                  i_mem_done,
  input  wire [7:0]            i_flash_rdata,
  input  wire [15:0]           i_sig_stored,
  output reg                   o_reply_valid,
  output reg  [63:0]           o_reply_frame,
  output reg                   o_busy,
  output reg                   o_commit,
  output reg                   o_ee_erase,
  output reg  [31:0]           o_sector_mask,
  output reg                   o_flash_rd,
  output reg  [SIG_ADDR_W-1:0] o_flash_addr,
  output reg                   o_sig_wr,
  output reg  [15:0]           o_sig_addr,
  output reg  [15:0]           o_sig_data,
  output reg  [3:0]            o_unlocked,
  output reg  [2:0]            o_rate_idx,
  output reg                   o_link_restart,
  output reg                   o_jump,
  output wire [15:0]           o_record_crc,
  output wire [15:0]           o_image_crc
);

  // ==========================================================
  // CRC byte update
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  b;
    integer      k;
    reg   [15:0] t;
    begin
      t = c ^ {8'h00, b};
      for (k = 0; k < 8; k = k + 1)
      begin
        if (t[0])
          t = (t >> 1) ^ `BCC_CRC_POLY;
        else
          t = t >> 1;
      end
      crc_byte = t;
    end
  endfunction

  // Reply frame build; byte 0 first on the link, in bits 63:56
  function [63:0] mk_reply;
    input [7:0] rc;
    input [7:0] cnt;
    input [7:0] b3;
    input [7:0] b4;
    input [7:0] b5;
    input [7:0] b7;
    begin
      mk_reply = {`BCC_REPLY_ID, rc, cnt, b3, b4, b5, 8'h00, b7};
    end
  endfunction

  // ==========================================================
  // States
  localparam [5:0] ST_IDLE = 6'b00_0001;
  localparam [5:0] ST_MEM  = 6'b00_0010;
  localparam [5:0] ST_SIG  = 6'b00_0100;
  localparam [5:0] ST_SIGW = 6'b00_1000;
  localparam [5:0] ST_JCHK = 6'b01_0000;
  localparam [5:0] ST_WAIT = 6'b10_0000;

  localparam [SIG_ADDR_W-1:0] SIG_STEP = {{(SIG_ADDR_W-8){1'b0}}, `BCC_SIG_STRIDE};

  reg [5:0]            state_ff;
  reg [15:0]           rec_crc_ff;
  reg [15:0]           img_crc_ff;
  reg [15:0]           sig_crc_ff;
  reg [63:0]           pend_reply_ff;
  reg [35:0]           tmo_ff;
  reg                  sig_rd_ff;

  wire [7:0]  op       = i_cmd_frame[63:56];
  wire [7:0]  cnt      = i_cmd_frame[55:48];
  wire [31:0] size     = i_cmd_frame[47:16];
  wire [15:0] host_crc = i_cmd_frame[15:0];
  wire [15:0] key      = {i_cmd_frame[39:32], i_cmd_frame[31:24]};
  wire [15:0] act_type = i_cmd_frame[47:32];
  wire [15:0] act_data = i_cmd_frame[31:16];
  wire        is_ee    = (i_region_sel == `BCC_REG_BOOTEE) ||
                         (i_region_sel == `BCC_REG_DATAEE);
  wire        take     = i_cmd_valid && (state_ff == ST_IDLE);

  assign o_record_crc = rec_crc_ff;
  assign o_image_crc  = img_crc_ff;

  // ==========================================================
  // Main sequencer
  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_ff       <= ST_IDLE;
      rec_crc_ff     <= `BCC_CRC_INIT;
      img_crc_ff     <= `BCC_CRC_INIT;
      sig_crc_ff     <= `BCC_CRC_INIT;
      pend_reply_ff  <= 64'h0000_0000_0000_0000;
      tmo_ff         <= 36'h0_0000_0000;
      sig_rd_ff      <= 1'b0;
      o_reply_valid  <= 1'b0;
      o_reply_frame  <= 64'h0000_0000_0000_0000;
      o_busy         <= 1'b0;
      o_commit       <= 1'b0;
      o_ee_erase     <= 1'b0;
      o_sector_mask  <= 32'h0000_0000;
      o_flash_rd     <= 1'b0;
      o_flash_addr   <= {SIG_ADDR_W{1'b0}};
      o_sig_wr       <= 1'b0;
      o_sig_addr     <= 16'h0000;
      o_sig_data     <= 16'h0000;
      o_unlocked     <= 4'h0;
      o_rate_idx     <= `BCC_RATE_DEFAULT;
      o_link_restart <= 1'b0;
      o_jump         <= 1'b0;
    end
    else
    begin
      // Pulses default low
      o_reply_valid  <= 1'b0;
      o_commit       <= 1'b0;
      o_ee_erase     <= 1'b0;
      o_flash_rd     <= 1'b0;
      o_sig_wr       <= 1'b0;
      o_link_restart <= 1'b0;
      o_jump         <= 1'b0;
      sig_rd_ff      <= 1'b0;
      // Both CRCs fold in buffered download bytes
      if (i_dl_valid)
      begin
        rec_crc_ff <= crc_byte(rec_crc_ff, i_dl_byte);
        img_crc_ff <= crc_byte(img_crc_ff, i_dl_byte);
      end
      // Busy is high in every state but idle and ST_WAIT; exits to idle clear it so take and busy agree
      o_busy <= (state_ff != ST_IDLE) && (state_ff != ST_WAIT);
      case (state_ff)
        ST_IDLE:
        begin
          if (take && op == `BCC_OP_CHECKSUM)
          begin
            if (size != 32'h0000_0000)
            begin
              // Record check; restart record CRC either way
              rec_crc_ff <= `BCC_CRC_INIT;
              if (host_crc == rec_crc_ff)
              begin
                o_commit  <= 1'b1;
                pend_reply_ff <= mk_reply(`BCC_RC_OK, cnt, i_region_sel,
                                 rec_crc_ff[15:8], rec_crc_ff[7:0], 8'h00);
                state_ff  <= ST_MEM;
                o_busy    <= 1'b1;
              end
              else
              begin
                o_reply_valid <= 1'b1;
                o_reply_frame <= mk_reply(`BCC_RC_ERR, cnt, 8'h00, 8'h00,
                                          8'h00, 8'h00);
              end
            end
            else if (host_crc == img_crc_ff)
            begin
              o_reply_valid <= 1'b1;
              o_reply_frame <= mk_reply(`BCC_RC_OK, cnt, i_region_sel,
                               img_crc_ff[15:8], img_crc_ff[7:0], 8'h00);
              if (i_region_sel == `BCC_REG_FLASH)
              begin
                // Signature walk then store
                sig_crc_ff   <= `BCC_CRC_INIT;
                o_flash_addr <= FLASH_BASE;
                o_flash_rd   <= 1'b1;
                sig_rd_ff    <= 1'b1;
                o_busy       <= 1'b1;
                state_ff     <= ST_SIG;
              end
            end
            else
            begin
              o_reply_valid <= 1'b1;
              o_reply_frame <= mk_reply(`BCC_RC_ERR, cnt, 8'h00, 8'h00,
                                        8'h00, 8'h00);
            end
          end
          else if (take && op == `BCC_OP_CLEAR)
          begin
            o_ee_erase    <= is_ee;
            o_sector_mask <= is_ee ? 32'h0000_0000 : size;
            pend_reply_ff <= mk_reply(`BCC_RC_OK, cnt, 8'h00, 8'h00,
                                      8'h00, 8'h00);
            o_busy        <= 1'b1;
            state_ff      <= ST_MEM;
          end
          else if (take && op == `BCC_OP_UNLOCK)
          begin
            o_reply_valid <= 1'b1;
            // Table lookup; no match leaves everything locked
            if (key == KEY_FLASH || key == KEY_BOOTEE || key == KEY_DATAEE)
            begin
              o_unlocked <= o_unlocked |
                            {key == KEY_DATAEE, key == KEY_BOOTEE,
                             1'b0, key == KEY_FLASH};
              o_reply_frame <= mk_reply(`BCC_RC_OK, cnt, i_region_sel, 8'h00,
                                        8'h00, `BCC_UNLOCK_TAG);
            end
            else
            begin
              o_unlocked    <= 4'h0;
              o_reply_frame <= mk_reply(`BCC_RC_ERR, cnt, 8'h00, 8'h00,
                                        8'h00, 8'h00);
            end
          end
          else if (take && op == `BCC_OP_ACTION)
          begin
            // Only a valid rate change acts; silent either way
            if (act_type == `BCC_ACT_RATE &&
                act_data <= {13'h0000, `BCC_RATE_MAX})
            begin
              o_rate_idx     <= act_data[2:0];
              o_link_restart <= 1'b1;
              rec_crc_ff     <= `BCC_CRC_INIT;
              tmo_ff         <= 36'h0_0000_0000;
              state_ff       <= ST_WAIT;
            end
          end
          else if (i_jump_req)
          begin
            // Recompute signature before any jump
            sig_crc_ff   <= `BCC_CRC_INIT;
            o_flash_addr <= FLASH_BASE;
            o_flash_rd   <= 1'b1;
            sig_rd_ff    <= 1'b1;
            o_busy       <= 1'b1;
            state_ff     <= ST_JCHK;
          end
        end
        ST_MEM:
        begin
          // Reply only once the memory side finishes
          if (i_mem_done)
          begin
            o_reply_valid <= 1'b1;
            o_reply_frame <= pend_reply_ff;
            o_sector_mask <= 32'h0000_0000;
            o_busy        <= 1'b0;
            state_ff      <= ST_IDLE;
          end
        end
        ST_SIG, ST_JCHK:
        begin
          // Read data one cycle after each strobe
          if (!sig_rd_ff)
          begin
            sig_crc_ff <= crc_byte(sig_crc_ff, i_flash_rdata);
            if (o_flash_addr > FLASH_LAST - SIG_STEP)
            begin
              if (state_ff == ST_SIG)
                state_ff <= ST_SIGW;
              else
              begin
                o_jump   <= (crc_byte(sig_crc_ff, i_flash_rdata) ==
                             i_sig_stored);
                o_busy   <= 1'b0;
                state_ff <= ST_IDLE;
              end
            end
            else
            begin
              o_flash_addr <= o_flash_addr + SIG_STEP;
              o_flash_rd   <= 1'b1;
              sig_rd_ff    <= 1'b1;
            end
          end
        end
        ST_SIGW:
        begin
          o_sig_wr   <= 1'b1;
          o_sig_addr <= EE_TOP_ADDR - 16'h0001;
          o_sig_data <= sig_crc_ff;
          o_busy     <= 1'b0;
          state_ff   <= ST_IDLE;
        end
        ST_WAIT:
        begin
          // Connect window after a rate restart
          tmo_ff <= tmo_ff + 36'h0_0000_0001;
          if (i_connect_seen)
            state_ff <= ST_IDLE;
          else if (tmo_ff >= CONN_TMO_CYC - 36'h0_0000_0001)
          begin
            sig_crc_ff   <= `BCC_CRC_INIT;
            o_busy       <= 1'b1;
            o_flash_addr <= FLASH_BASE;
            o_flash_rd   <= 1'b1;
            sig_rd_ff    <= 1'b1;
            state_ff     <= ST_JCHK;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule

// [verilog/bcc_defs.vh]
// Constants for the boot command interpreter (checksum, clear, unlock, action)
// Included by bcc_core.v; holds definitions only.
`ifndef BCC_DEFS_VH
`define BCC_DEFS_VH
// Opcodes
`define BCC_OP_CHECKSUM   8'h0E
`define BCC_OP_CLEAR      8'h10
`define BCC_OP_UNLOCK     8'h13
`define BCC_OP_ACTION     8'h21
`define BCC_OP_CONNECT    8'h01
// Reply constants
`define BCC_REPLY_ID      8'hFF
`define BCC_RC_OK         8'h00
`define BCC_RC_ERR        8'h01
`define BCC_UNLOCK_TAG    8'h02
// Region selector codes
`define BCC_REG_FLASH     8'h00
`define BCC_REG_CFG       8'h01
`define BCC_REG_BOOTEE    8'h02
`define BCC_REG_DATAEE    8'h03
// CRC
`define BCC_CRC_INIT      16'hFFFF
`define BCC_CRC_POLY      16'hA001
// Action
`define BCC_ACT_RATE      16'h0081
`define BCC_RATE_MAX      3'd5
`define BCC_RATE_DEFAULT  3'd2
// Signature sampling stride (flash locations)
`define BCC_SIG_STRIDE    8'h80
// Connect timeout after rate change; 36 bits so the cycle product cannot wrap
`define BCC_CONN_TMO_S    36'h0_0000_001E
`define BCC_CLK_HZ        36'h0_0BEB_C200
`endif
